// ==== acs_far_side.sv ====
// Far side model: analog source, trigger units, RC oscillator
// Assumes the bench steers the level and the trigger pulses
`timescale 1ns/1ps
module acs_far_side (
   input  wire logic          clk_sys,
   input  wire logic          converting,
   input  wire logic [11:0]   level,
   input  wire logic [3:0]    fire,
   output logic [11:0]        converter_code,
   output acs_pkg::acs_trig_t trig_in,
   output logic               rc_clk_pin
);
   // ------------------------------
   // Sources
   // ------------------------------
   logic [11:0] noise = 12'h5a5;
   initial rc_clk_pin = 1'b0;
   always #130 rc_clk_pin = ~rc_clk_pin;
   always @(posedge clk_sys) noise <= ~noise;
   // Code valid only while converting
   assign converter_code = converting ? level : noise;
   assign trig_in = fire;
endmodule

// ==== acs_pkg.sv ====
// Constants and carrier types for the converter sequencer
// Assumes one system clock and a separate RC clock input on a pin
// Overview of operation
// - Zero acquisition code: go starts conversion directly
// - Acquisition field bits 5:3, resets zero
// - Nonzero code: sample selected periods, then convert
// - Code 010 gives four periods acquisition
// - Done clears go, sets flag; sampling resumes after the wait
// - Go stays set through acquisition and conversion
// - Conversion lasts fourteen bit periods
// - Clock select maps divides; x11 picks RC
// - Clearing go aborts, no partial result
// - Abort keeps last or written result
// - Two period wait before next acquisition
// - Zero code: start after following instruction
// - Special-event triggers set go, start acquisition
// - Converter off: no trigger sets go or starts acquisition
// - Compare trigger clears timer even when off
// - Analog pins read zero on port
// - Reset turns converter off, aborts conversion (here converter_on is an input that reset leaves alone; reset only aborts)
// - Result loaded on the same clock edge as done indication
// - Format bit set gives right justification
package acs_pkg;
   localparam int          ACQ_LSB         = 3;
   localparam int          ACQ_MSB         = 5;
   localparam int          CLK_LSB         = 0;
   localparam int          CLK_MSB         = 2;
   localparam int          FMT_BIT         = 7;
   localparam logic [7:0]  TIMING_RESET    = 8'h00;
   localparam logic [4:0]  CONV_PERIODS    = 5'h0e;
   localparam logic [4:0]  WAIT_PERIODS    = 5'h02;
   localparam logic [4:0]  START_DELAY     = 5'h01;
   localparam logic [3:0]  CMP_TRIG_MODE   = 4'hb;
   localparam int          PORT_W          = 15;
   localparam int          RESULT_W        = 12;

   typedef enum logic [2:0] {ACS_IDLE, ACS_DELAY, ACS_ACQ, ACS_CONV, ACS_WAIT} acs_state_t;

   typedef struct packed {
      logic second_compare;
      logic enhanced_compare;
      logic charge_time;
      logic timer_one;
   } acs_trig_t;

   typedef struct packed {
      logic [7:0] high;
      logic [7:0] low;
   } acs_result_t;
endpackage

// ==== acs_sequencer.sv ====
// Acquisition and conversion sequencer with result and port read-back
// Assumes a 12-bit converter core that delivers its code at the last period
`timescale 1ns/1ps
module acs_sequencer (
   input  wire logic                             clk_sys,
   input  wire logic                             rst_n,
   input  wire logic [7:0]                       conversion_timing_control,
   input  wire logic                             converter_on,
   input  wire logic                             go_set,
   input  wire logic                             go_clear,
   input  wire logic                             result_write_high,
   input  wire logic                             result_write_low,
   input  wire logic [7:0]                       result_write_data,
   input  wire logic [11:0]                      converter_code,
   input  wire logic                             rc_clk_pin,
   input  wire acs_pkg::acs_trig_t               trig_in,
   input  wire logic [3:0]                       second_compare_mode,
   input  wire logic                             charge_time_trigger_enable,
   input  wire logic                             done_flag_clear,
   input  wire logic [acs_pkg::PORT_W-1:0]       port_pins,
   input  wire logic [acs_pkg::PORT_W-1:0]       analog_select,
   output logic                                  go_flag,
   output logic                                  conversion_done_irq_flag,
   output logic                                  sampling,
   output logic                                  converting,
   output acs_pkg::acs_result_t                  result,
   output logic                                  timer_clear,
   output logic [acs_pkg::PORT_W-1:0]            port_read
);
   // ---------------------------------------------
   // Field decode
   // ---------------------------------------------
   logic [2:0]          acquisition_time_select;
   logic [2:0]          conversion_clock_select;
   logic                result_format_select;
   logic                tick;
   logic                restart;
   logic                trig_hit;
   logic                cmp_trig;
   logic                go_req;
   logic                state_busy;
   logic                abort;
   logic                finish;
   logic [4:0]          acq_periods;
   logic [4:0]          cnt;
   logic [4:0]          next_cnt;
   acs_pkg::acs_state_t state;
   acs_pkg::acs_state_t next_state;
   acs_pkg::acs_result_t next_result;
   logic [acs_pkg::PORT_W-1:0] pin_s1;
   logic [acs_pkg::PORT_W-1:0] pin_s2;
   logic [acs_pkg::PORT_W-1:0] pin_s3;
   logic [acs_pkg::PORT_W-1:0] pin_level;

   function automatic logic [4:0] acq_count(input logic [2:0] code);
      case (code)
         3'h1:    acq_count = 5'h02;
         3'h2:    acq_count = 5'h04;
         3'h3:    acq_count = 5'h06;
         3'h4:    acq_count = 5'h08;
         3'h5:    acq_count = 5'h0c;
         3'h6:    acq_count = 5'h10;
         3'h7:    acq_count = 5'h14;
         default: acq_count = 5'h00;
      endcase
   endfunction

   function automatic acs_pkg::acs_result_t justify(input logic [11:0] code, input logic fmt);
      if (fmt) begin
         justify = {{4{code[11]}}, code[11:8], code[7:0]};
      end else begin
         justify = {code[11:4], code[3:0], {4{code[11]}}};
      end
   endfunction

   assign acquisition_time_select = conversion_timing_control[acs_pkg::ACQ_MSB:acs_pkg::ACQ_LSB];
   assign conversion_clock_select = conversion_timing_control[acs_pkg::CLK_MSB:acs_pkg::CLK_LSB];
   assign result_format_select    = conversion_timing_control[acs_pkg::FMT_BIT];
   assign acq_periods             = acq_count(acquisition_time_select);

   // ---------------------------------------------
   // Trigger handling
   // ---------------------------------------------
   assign cmp_trig   = (trig_in.second_compare && second_compare_mode == acs_pkg::CMP_TRIG_MODE)
                       || trig_in.enhanced_compare;
   assign trig_hit   = cmp_trig || (trig_in.charge_time && charge_time_trigger_enable)
                       || trig_in.timer_one;
   assign timer_clear = cmp_trig;
   assign state_busy = (state == acs_pkg::ACS_DELAY) || (state == acs_pkg::ACS_ACQ)
                       || (state == acs_pkg::ACS_CONV);
   assign go_req     = converter_on && (go_set || trig_hit);
   assign abort      = state_busy && (go_clear || !converter_on);
   assign finish     = (state == acs_pkg::ACS_CONV) && tick && (cnt == acs_pkg::CONV_PERIODS - 5'h01);
   assign restart    = (next_state != state);

   acs_tick_gen u_tick (
      .clk_sys                 (clk_sys),
      .rst_n                   (rst_n),
      .conversion_clock_select (conversion_clock_select),
      .rc_clk_pin              (rc_clk_pin),
      .restart                 (restart),
      .tick                    (tick)
   );

   // ---------------------------------------------
   // Sequencing
   // ---------------------------------------------
   always_comb begin
      next_state = state;
      next_cnt   = cnt;
      case (state)
         acs_pkg::ACS_IDLE: begin
            if (go_req && !go_clear) begin
               if (acq_periods == 5'h00) begin
                  next_state = acs_pkg::ACS_DELAY;
               end else begin
                  next_state = acs_pkg::ACS_ACQ;
               end
            end
         end
         acs_pkg::ACS_DELAY: begin
            if (cnt == acs_pkg::START_DELAY) begin
               next_state = acs_pkg::ACS_CONV;
            end
         end
         acs_pkg::ACS_ACQ: begin
            if (tick && cnt == acq_periods - 5'h01) begin
               next_state = acs_pkg::ACS_CONV;
            end
         end
         acs_pkg::ACS_CONV: begin
            if (finish) begin
               next_state = acs_pkg::ACS_WAIT;
            end
         end
         acs_pkg::ACS_WAIT: begin
            if (tick && cnt == acs_pkg::WAIT_PERIODS - 5'h01) begin
               next_state = acs_pkg::ACS_IDLE;
            end
         end
         default: next_state = acs_pkg::ACS_IDLE;
      endcase
      if (abort) begin
         next_state = acs_pkg::ACS_WAIT;
      end
      if (next_state != state) begin
         next_cnt = 5'h00;
      end else if (state == acs_pkg::ACS_DELAY || tick) begin
         next_cnt = cnt + 5'h01;
      end
   end

   always_comb begin
      next_result = result;
      if (finish && !abort) begin
         next_result = justify(converter_code, result_format_select);
      end else begin
         if (result_write_high) begin
            next_result.high = result_write_data;
         end
         if (result_write_low) begin
            next_result.low = result_write_data;
         end
      end
   end

   assign sampling   = (state == acs_pkg::ACS_IDLE) || (state == acs_pkg::ACS_ACQ)
                       || (state == acs_pkg::ACS_DELAY);
   assign converting = (state == acs_pkg::ACS_CONV);

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         state <= acs_pkg::ACS_IDLE;
         cnt   <= 5'h00;
      end else begin
         state <= next_state;
         cnt   <= next_cnt;
      end
   end

   // Result has no reset: contents unknown after power-on
   always_ff @(posedge clk_sys) begin
      result <= next_result;
   end

   // ---------------------------------------------
   // Go and done flags
   // ---------------------------------------------
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         go_flag                  <= 1'b0;
         conversion_done_irq_flag <= 1'b0;
      end else begin
         if (finish && !abort) begin
            go_flag <= 1'b0;
         end else if (state == acs_pkg::ACS_IDLE && go_req && !go_clear) begin
            go_flag <= 1'b1;
         end else if (abort) begin
            go_flag <= 1'b0;
         end
         if (finish && !abort) begin
            conversion_done_irq_flag <= 1'b1;
         end else if (done_flag_clear) begin
            conversion_done_irq_flag <= 1'b0;
         end
      end
   end

   // ---------------------------------------------
   // Port read-back
   // ---------------------------------------------
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         pin_s1    <= '0;
         pin_s2    <= '0;
         pin_s3    <= '0;
         pin_level <= '0;
         port_read <= '0;
      end else begin
         pin_s1 <= port_pins;
         pin_s2 <= pin_s1;
         pin_s3 <= pin_s2;
         for (int i = 0; i < acs_pkg::PORT_W; i++) begin
            if (pin_s2[i] == pin_s3[i]) begin
               pin_level[i] <= pin_s3[i];
            end
         end
         port_read <= pin_level & ~analog_select;
      end
   end
endmodule

// ==== acs_sequencer_sva.sv ====
// Port checker for the converter sequencer
// Assumes a bind onto acs_sequencer with one clock domain
`timescale 1ns/1ps
module acs_sequencer_sva (
   input wire logic                 clk_sys,
   input wire logic                 rst_n,
   input wire logic [7:0]           conversion_timing_control,
   input wire logic                 converter_on,
   input wire logic                 go_set,
   input wire logic                 go_clear,
   input wire logic [14:0]          analog_select,
   input wire logic                 go_flag,
   input wire logic                 conversion_done_irq_flag,
   input wire logic                 sampling,
   input wire logic                 converting,
   input wire acs_pkg::acs_result_t result,
   input wire logic [14:0]          port_read
);
   // ------------------------------
   // Helper logic and assertions
   // ------------------------------
   logic [9:0]      conv_len;
   wire logic       fast = (conversion_timing_control[2:0] == 3'h0);
   wire logic [2:0] acq  = conversion_timing_control[5:3];
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) conv_len <= 10'h000;
      else conv_len <= converting ? conv_len + 10'h001 : 10'h000;
   end
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!rst_n);
   AST_GO: assert property (go_set && converter_on && !go_clear && sampling && !go_flag
      |=> go_flag) else $error("start not taken");
   AST_ZERO: assert property ($rose(go_flag) && acq == 3'h0 && fast
      |-> !converting ##1 !converting ##1 converting) else $error("direct start late");
   AST_ACQ4: assert property ($rose(go_flag) && acq == 3'h2 && fast
      |-> !converting[*8] ##1 converting) else $error("acquisition not four periods");
   AST_CONV: assert property ($rose(conversion_done_irq_flag) && fast
      |-> conv_len == 10'h01c) else $error("conversion length wrong");
   AST_DONE: assert property ($rose(conversion_done_irq_flag)
      |-> $fell(go_flag) && !converting) else $error("done without go clear");
   AST_HOLD: assert property (converting |-> go_flag) else $error("go low while busy");
   AST_ABORT: assert property (go_clear && converting
      |=> !go_flag && $stable(result) && !$rose(conversion_done_irq_flag))
      else $error("abort failed");
   AST_WAIT: assert property ($fell(go_flag) && fast
      |-> !sampling[*4] ##1 sampling) else $error("wait not two periods");
   AST_OFF: assert property (!converter_on && !go_flag |=> !go_flag)
      else $error("start while off");
   AST_PORT: assert property ((port_read & analog_select & $past(analog_select)) == 15'h0000)
      else $error("analog pin reads high");
endmodule
bind acs_sequencer acs_sequencer_sva chk_u (.clk_sys, .rst_n, .conversion_timing_control,
   .converter_on, .go_set, .go_clear, .analog_select, .go_flag, .conversion_done_irq_flag,
   .sampling, .converting, .result, .port_read);

// ==== acs_tick_gen.sv ====
// Bit conversion period generator
// Assumes the RC clock arrives asynchronously on a pin
`timescale 1ns/1ps
module acs_tick_gen (
   input  wire logic       clk_sys,
   input  wire logic       rst_n,
   input  wire logic [2:0] conversion_clock_select,
   input  wire logic       rc_clk_pin,
   input  wire logic       restart,
   output logic            tick
);
   // ---------------------------------------------
   // Divide selection
   // ---------------------------------------------
   logic [6:0] div_ratio;
   logic [6:0] div_cnt;
   logic [2:0] rc_sync;
   logic       rc_level;
   logic       use_rc;
   logic       div_tick;
   logic       rc_tick;

   function automatic logic [6:0] ratio_of(input logic [2:0] sel);
      case (sel)
         3'h0:    ratio_of = 7'h02;
         3'h4:    ratio_of = 7'h04;
         3'h1:    ratio_of = 7'h08;
         3'h5:    ratio_of = 7'h10;
         3'h2:    ratio_of = 7'h20;
         3'h6:    ratio_of = 7'h40;
         default: ratio_of = 7'h02;
      endcase
   endfunction

   assign div_ratio = ratio_of(conversion_clock_select);
   assign use_rc    = (conversion_clock_select[1:0] == 2'h3);
   assign div_tick  = (div_cnt == div_ratio - 7'h01);
   assign rc_tick   = (rc_sync[2] == rc_sync[1]) && rc_sync[2] && !rc_level;
   // Restart only clears the divider, so tick never loops back through the state decode
   assign tick      = use_rc ? rc_tick : div_tick;

   // ---------------------------------------------
   // Counters and RC synchroniser
   // ---------------------------------------------
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         div_cnt  <= 7'h00;
         rc_sync  <= 3'h0;
         rc_level <= 1'b0;
      end else begin
         rc_sync <= {rc_sync[1:0], rc_clk_pin};
         if (rc_sync[2] == rc_sync[1]) begin
            rc_level <= rc_sync[2];
         end
         if (restart || div_tick) begin
            div_cnt <= 7'h00;
         end else begin
            div_cnt <= div_cnt + 7'h01;
         end
      end
   end
endmodule

// ==== adc_acquire_convert_sequencer_tb.sv ====
// Self-checking bench for the converter sequencer
// Assumes acs_pkg, acs_sequencer, its checker and acs_far_side
`timescale 1ns/1ps
module adc_acquire_convert_sequencer_tb;
   // ------------------------------
   // Signals, instances and tasks
   // ------------------------------
   logic        clk_sys = 1'b0, rst_n = 1'b0, on = 1'b0, go_set = 1'b0, go_clear = 1'b0;
   logic        wr_hi = 1'b0, wr_lo = 1'b0, cte = 1'b1, done_clr = 1'b0, prev_done = 1'b0;
   logic        go_flag, done_flag, sampling, converting, timer_clear, rc_clk;
   logic [3:0]  fire = 4'h0, cmp_mode = 4'hb;
   logic [7:0]  timing = 8'h00, wr_data = 8'h00;
   logic [11:0] level = 12'h000, code;
   logic [14:0] pins = 15'h0000, ana = 15'h0000, port_read;
   acs_pkg::acs_trig_t   trig;
   acs_pkg::acs_result_t result, exp_q[$];
   int failures = 0, checks_done = 0, seed = 32, n;
   int acq_cnt[8] = '{0, 2, 4, 6, 8, 12, 16, 20};
   always #10 clk_sys = ~clk_sys;
   acs_sequencer dut_u (.clk_sys, .rst_n, .conversion_timing_control(timing),
      .converter_on(on), .go_set, .go_clear, .result_write_high(wr_hi),
      .result_write_low(wr_lo), .result_write_data(wr_data), .converter_code(code),
      .rc_clk_pin(rc_clk), .trig_in(trig), .second_compare_mode(cmp_mode),
      .charge_time_trigger_enable(cte), .done_flag_clear(done_clr), .port_pins(pins),
      .analog_select(ana), .go_flag, .conversion_done_irq_flag(done_flag), .sampling,
      .converting, .result, .timer_clear, .port_read);
   acs_far_side far_u (.clk_sys, .converting, .level, .fire, .converter_code(code),
      .trig_in(trig), .rc_clk_pin(rc_clk));
   task automatic tick(input int k);
      repeat (k) @(negedge clk_sys);
   endtask
   task automatic pulse(ref logic s);
      s = 1'b1;
      tick(1);
      s = 1'b0;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp) begin
         failures++;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic wrap_up();
      $display("Counts: %0d checks, %0d failures", checks_done, failures);
      if (failures == 0 && checks_done > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask
   task automatic convert(input logic [2:0] acq, sel, input logic [4:0] how, input int len);
      level = 12'($random(seed));
      timing = {level[0], 1'b0, acq, sel};
      if (len != 0) exp_q.push_back(level[0] ? {{4{level[11]}}, level} : {level, {4{level[11]}}});
      tick(4);
      go_set = how[4];
      fire = how[3:0];
      #1;
      chk(32'(timer_clear), 32'(how[2] | (how[3] & (cmp_mode == 4'hb))));
      tick(1);
      go_set = 1'b0;
      fire = 4'h0;
      for (n = 0; go_flag === 1'b1 && n < 3000; n++) tick(1);
      if (len >= 0) chk(32'(n), 32'(len));
      pulse(done_clr);
      for (n = 0; sampling !== 1'b1 && n < 200; n++) tick(1);
   endtask
   // Result monitor: one note per done rise
   always @(negedge clk_sys) begin
      prev_done <= done_flag;
      if (done_flag === 1'b1 && prev_done === 1'b0) begin
         if (exp_q.size() == 0) chk(32'h0, 32'h1);
         else chk(32'(result), 32'(exp_q.pop_front()));
      end
   end
   initial begin
      #1000000;
      failures++;
      wrap_up();
   end
   initial begin
      tick(20);
      chk(32'({go_flag, done_flag, sampling, converting, port_read}), 32'h10000);
      rst_n = 1'b1;
      on = 1'b1;
      tick(2);
      for (int i = 0; i < 8; i++) begin
         convert(3'(i), 3'h0, 5'h10, 2 * (acq_cnt[i] + 14) + (i == 0 ? 2 : 0));
      end
      $display("Test acquisition codes done");
      for (int i = 0; i < 6; i++) begin
         convert(3'h0, {i[0], i[2:1]}, 5'h10, 2 + 14 * (2 << i));
      end
      convert(3'h0, 3'h3, 5'h10, -1);
      convert(3'h2, 3'h7, 5'h10, -1);
      $display("Test clock selects done");
      for (int i = 0; i < 8; i++) begin
         on = (i < 4);
         convert(3'h0, 3'h0, 5'(1 << (i % 4)), on ? 30 : 0);
      end
      on = 1'b1;
      cmp_mode = 4'h0;
      cte = 1'b0;
      convert(3'h0, 3'h0, 5'h08, 0);
      convert(3'h0, 3'h0, 5'h02, 0);
      $display("Test triggers done");
      wr_data = 8'h3c;
      pulse(wr_hi);
      wr_data = 8'ha5;
      pulse(wr_lo);
      pulse(go_set);
      tick(8);
      pulse(go_clear);
      chk(32'({go_flag, converting, result}), 32'h3ca5);
      tick(10);
      pulse(go_set);
      tick(8);
      rst_n = 1'b0;
      tick(1);
      chk(32'({go_flag, done_flag, sampling, converting}), 32'h2);
      rst_n = 1'b1;
      tick(2);
      $display("Test abort and reset done");
      for (int i = 0; i < 4; i++) begin
         pins = 15'($random(seed));
         ana = 15'($random(seed));
         tick(8);
         chk(32'(port_read), 32'(pins & ~ana));
      end
      $display("Test port read-back done");
      wrap_up();
   end
endmodule
